// ---- cmp_pkg.sv ----
package cmp_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BANKS = 2;
  localparam int BANK_W = 1;
  localparam int STRAP_W = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ACCESS_TIME_NS = 8;
  localparam int ACCESS_CYCLES =
    (ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Strap vector positions and reset values
  // ----------------------------------------------------------------
  localparam int STRAP_ARB_BIT = 0;
  localparam int STRAP_ENDIAN_BIT = 1;
  localparam int STRAP_CTRL_BIT = 2;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_WAIT    = 6'b000010,
    ST_CLAIM   = 6'b000100,
    ST_ACCESS  = 6'b001000,
    ST_DONE    = 6'b010000,
    ST_BACKOFF = 6'b100000
  } cmp_state_e;

  typedef struct packed {
    logic write;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cmp_req_s;

  typedef struct packed {
    logic [BANKS-1:0] bank_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ctrl_oe;
    logic data_oe;
  } cmp_mem_s;

  localparam logic [BANKS-1:0] BANK_NONE = 2'h3;

endpackage

// ---- cmp_strap_latch.sv ----
`timescale 1ns/1ps

module cmp_strap_latch
  import cmp_pkg::*;
#(
  parameter int W = STRAP_W
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] straps
);

  typedef struct packed {
    logic [W-1:0] straps;
  } cmp_latch_s;

  cmp_latch_s s_q, s_d;

  // Track the pins through reset; freeze on the first cycle out of it
  always_comb
  begin
    s_d = s_q;
    if (rst)
    begin
      s_d.straps = pins; // [R14]
    end
  end

  always_ff @(posedge clk)
  begin
    s_q <= s_d;
  end

  assign straps = s_q.straps;

endmodule

// ---- cmp_top.sv ----
`timescale 1ns/1ps

// Contract
// [R1] Drive two active-low bank selects, asserting the accessed bank's one.
// [R2] Assert active-low read strobe while fetching from memory.
// [R3] Assert active-low write strobe while storing into memory.
// [R4] Present the accessed location on a 16-bit address bus.
// [R5] One 32-bit tri-stateable data bus carries read and write data.
// [R6] Accept partner occupied input meaning the partner holds the interface.
// [R7] Drive occupied output while this device holds the interface.
// [R8] Arbitration strap high means master, low slave; board ties opposite.
// [R9] Byte-order strap high selects big-endian host data, low little-endian.
// [R10] Control-source strap high means link control, low local host control.
// [R11] System holds reset at power-up for five link reference clocks.
// [R12] Reset brings all internal state to a defined condition.
// [R13] Memory outputs can release to high impedance for shared wiring.
// [R14] Straps are captured as reset is released and must be stable.
// [R15] Start only while partner free; occupied spans access; float otherwise.
module cmp_top
  import cmp_pkg::*;
#(
  parameter int ACC_CYC = ACCESS_CYCLES
)(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic ARB_MASTER_STRAP,
  input wire logic HOST_BYTE_ORDER_STRAP,
  input wire logic CONTROL_SOURCE_STRAP,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [BANK_W-1:0] REQ_BANK,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [DATA_W-1:0] RD_DATA,
  output logic ARB_IS_MASTER,
  output logic HOST_BIG_ENDIAN,
  output logic LINK_CONTROL,
  output logic [BANKS-1:0] MEM_BANK_SELECT_N,
  output logic MEM_READ_STROBE_N,
  output logic MEM_WRITE_STROBE_N,
  output logic [ADDR_W-1:0] MEM_ADDR_BUS,
  output logic MEM_CTRL_OE,
  input wire logic [DATA_W-1:0] MEM_DATA_BUS_IN,
  output logic [DATA_W-1:0] MEM_DATA_BUS_OUT,
  output logic MEM_DATA_BUS_OE,
  input wire logic PARTNER_OCCUPIED_IN,
  output logic OCCUPIED_OUT,
  output logic OCCUPIED_OE
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    cmp_state_e state;
    cmp_req_s req;
    cmp_mem_s mem;
    logic [CNT_W-1:0] cnt;
    logic occupied;
    logic ready;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
  } cmp_top_s;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ACC_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  cmp_top_s s_q, s_d;
  logic [STRAP_W-1:0] straps;
  logic is_master;
  logic big_endian;

  cmp_strap_latch #(
    .W(STRAP_W)
  ) u_straps (
    .clk(CLOCK),
    .rst(RESET),
    .pins({CONTROL_SOURCE_STRAP, HOST_BYTE_ORDER_STRAP, ARB_MASTER_STRAP}),
    .straps(straps)
  );

  assign is_master = straps[STRAP_ARB_BIT]; // [R8]
  assign big_endian = straps[STRAP_ENDIAN_BIT]; // [R9]

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] order(input logic [DATA_W-1:0] d,
                                              input logic swap);
    logic [DATA_W-1:0] r;
    r = d;
    if (swap)
    begin
      for (int i = 0; i < DATA_W / 8; i++)
      begin
        r[i*8 +: 8] = d[DATA_W - 8 - i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic cmp_mem_s mem_idle();
    cmp_mem_s m;
    m.bank_select_n = BANK_NONE;
    m.read_strobe_n = 1'b1;
    m.write_strobe_n = 1'b1;
    m.addr = '0;
    m.wdata = '0;
    m.ctrl_oe = 1'b0;
    m.data_oe = 1'b0;
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    case (s_q.state)
      ST_IDLE:
      begin
        if (REQ_VALID && s_q.ready)
        begin
          s_d.req.write = REQ_WRITE;
          s_d.req.bank = REQ_BANK;
          s_d.req.addr = REQ_ADDR;
          s_d.req.wdata = order(REQ_WDATA, big_endian); // [R9]
          s_d.state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // Claim only a free interface
        if (!PARTNER_OCCUPIED_IN) // [R6] [R15]
        begin
          s_d.occupied = 1'b1; // [R7]
          s_d.state = ST_CLAIM;
        end
      end
      ST_CLAIM:
      begin
        // Both claimed in the same cycle: the slave yields
        if (PARTNER_OCCUPIED_IN && !is_master) // [R8] [R15]
        begin
          s_d.occupied = 1'b0;
          s_d.state = ST_BACKOFF;
        end
        else
        begin
          s_d.mem.ctrl_oe = 1'b1; // [R13]
          s_d.mem.bank_select_n = ~(BANKS'(1) << s_q.req.bank); // [R1]
          s_d.mem.addr = s_q.req.addr; // [R4]
          s_d.mem.read_strobe_n = s_q.req.write; // [R2]
          s_d.mem.write_strobe_n = !s_q.req.write; // [R3]
          s_d.mem.wdata = s_q.req.wdata; // [R5]
          s_d.mem.data_oe = s_q.req.write; // [R5] [R13]
          s_d.cnt = CNT_ZERO;
          s_d.state = ST_ACCESS;
        end
      end
      ST_ACCESS:
      begin
        if (s_q.cnt >= CNT_LAST)
        begin
          s_d.mem.bank_select_n = BANK_NONE;
          s_d.mem.read_strobe_n = 1'b1;
          s_d.mem.write_strobe_n = 1'b1;
          if (!s_q.req.write)
          begin
            s_d.rd_data = order(MEM_DATA_BUS_IN, big_endian); // [R5] [R9]
            s_d.rd_valid = 1'b1;
          end
          s_d.state = ST_DONE;
        end
        else
        begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      ST_DONE:
      begin
        // Strobes already high; data held one more cycle, then float
        s_d.mem = mem_idle(); // [R13] [R15]
        s_d.occupied = 1'b0; // [R7]
        s_d.state = ST_IDLE;
      end
      ST_BACKOFF:
      begin
        s_d.state = ST_WAIT;
      end
      default:
      begin
        s_d.state = ST_IDLE;
        s_d.mem = mem_idle();
        s_d.occupied = 1'b0;
      end
    endcase
    s_d.ready = (s_d.state == ST_IDLE);
    if (RESET)
    begin
      s_d.state = ST_IDLE; // [R12]
      s_d.req = '0;
      s_d.mem = mem_idle();
      s_d.cnt = CNT_ZERO;
      s_d.occupied = 1'b0;
      s_d.ready = 1'b0;
      s_d.rd_valid = 1'b0;
      s_d.rd_data = '0;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REQ_READY = s_q.ready;
  assign RD_VALID = s_q.rd_valid;
  assign RD_DATA = s_q.rd_data;
  assign ARB_IS_MASTER = straps[STRAP_ARB_BIT];
  assign HOST_BIG_ENDIAN = straps[STRAP_ENDIAN_BIT];
  assign LINK_CONTROL = straps[STRAP_CTRL_BIT]; // [R10]
  assign MEM_BANK_SELECT_N = s_q.mem.bank_select_n;
  assign MEM_READ_STROBE_N = s_q.mem.read_strobe_n;
  assign MEM_WRITE_STROBE_N = s_q.mem.write_strobe_n;
  assign MEM_ADDR_BUS = s_q.mem.addr;
  assign MEM_CTRL_OE = s_q.mem.ctrl_oe;
  assign MEM_DATA_BUS_OUT = s_q.mem.wdata;
  assign MEM_DATA_BUS_OE = s_q.mem.data_oe;
  // Wired with the partner: drive only while asserted
  assign OCCUPIED_OUT = s_q.occupied;
  assign OCCUPIED_OE = s_q.occupied;

endmodule

// ---- cmp_props.sv ----
`timescale 1ns/1ps
module cmp_props
  import cmp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PARTNER_OCCUPIED_IN,
  input wire logic ARB_IS_MASTER,
  input wire logic HOST_BIG_ENDIAN,
  input wire logic LINK_CONTROL,
  input wire logic [BANKS-1:0] MEM_BANK_SELECT_N,
  input wire logic MEM_READ_STROBE_N,
  input wire logic MEM_WRITE_STROBE_N,
  input wire logic MEM_CTRL_OE,
  input wire logic MEM_DATA_BUS_OE,
  input wire logic OCCUPIED_OUT,
  input wire logic OCCUPIED_OE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  property p_bank;
    !(MEM_READ_STROBE_N & MEM_WRITE_STROBE_N) |-> $onehot(~MEM_BANK_SELECT_N);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select");
  property p_strb;
    MEM_READ_STROBE_N | MEM_WRITE_STROBE_N;
  endproperty
  a_strb: assert property (p_strb) else $error("both strobes");
  property p_own;
    !(MEM_READ_STROBE_N & MEM_WRITE_STROBE_N) |-> OCCUPIED_OUT & MEM_CTRL_OE;
  endproperty
  a_own: assert property (p_own) else $error("unowned access");
  property p_float;
    !OCCUPIED_OUT |-> !MEM_CTRL_OE & !MEM_DATA_BUS_OE;
  endproperty
  a_float: assert property (p_float) else $error("not floating");
  property p_oe;
    OCCUPIED_OE == OCCUPIED_OUT;
  endproperty
  a_oe: assert property (p_oe) else $error("occupied enable");
  property p_claim;
    $rose(OCCUPIED_OUT) |-> !$past(PARTNER_OCCUPIED_IN);
  endproperty
  a_claim: assert property (p_claim) else $error("claim while busy");
  property p_strap;
    !$past(RESET) |-> $stable({ARB_IS_MASTER, HOST_BIG_ENDIAN, LINK_CONTROL});
  endproperty
  a_strap: assert property (p_strap) else $error("strap moved");
  property p_rst;
    $fell(RESET) |-> MEM_BANK_SELECT_N == BANK_NONE && !OCCUPIED_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule

bind cmp_top cmp_props i_props (.CLOCK, .RESET, .PARTNER_OCCUPIED_IN,
  .ARB_IS_MASTER, .HOST_BIG_ENDIAN, .LINK_CONTROL, .MEM_BANK_SELECT_N,
  .MEM_READ_STROBE_N, .MEM_WRITE_STROBE_N, .MEM_CTRL_OE, .MEM_DATA_BUS_OE,
  .OCCUPIED_OUT, .OCCUPIED_OE);

// ---- cmp_mem_model.sv ----
`timescale 1ns/1ps
module cmp_mem_model
  import cmp_pkg::*;
(
  input wire logic clk,
  input wire logic [BANKS-1:0] sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] bus,
  output logic [DATA_W-1:0] dout
);
  logic [DATA_W-1:0] mem [128];
  logic [DATA_W-1:0] junk = 32'h5a5a_a5a5;
  wire [6:0] idx = {sel_n[0], addr[5:0]};
  // Released bus toggles so stale data never looks valid
  always @(posedge clk)
  begin
    junk <= ~junk;
    if (!wr_n && sel_n != BANK_NONE)
      mem[idx] <= bus;
  end
  assign dout = (!rd_n && sel_n != BANK_NONE) ? mem[idx] : junk;
endmodule

// ---- cmp_top_test.sv ----
`timescale 1ns/1ps
module cmp_top_test
  import cmp_pkg::*;
;
  logic CLOCK = 0, RESET = 1, PARTNER_OCCUPIED_IN = 0;
  logic REQ_VALID = 0, REQ_WRITE = 0;
  logic [BANK_W-1:0] REQ_BANK = 0;
  logic [ADDR_W-1:0] REQ_ADDR = 0, MEM_ADDR_BUS;
  logic [DATA_W-1:0] REQ_WDATA = 0, RD_DATA, bus_out, mdl_out, bus, w;
  logic REQ_READY, RD_VALID, ARB_IS_MASTER, HOST_BIG_ENDIAN, LINK_CONTROL;
  logic [BANKS-1:0] MEM_BANK_SELECT_N;
  logic MEM_READ_STROBE_N, MEM_WRITE_STROBE_N, MEM_CTRL_OE, bus_oe;
  logic OCCUPIED_OUT, OCCUPIED_OE;
  logic [2:0] strap = 0, cfg;
  logic [17:0] seen;
  int error_cnt = 0, num_checks = 0, cyc = 0, n;
  assign bus = bus_oe ? bus_out : mdl_out;
  cmp_top i_cmp_top (.CLOCK, .RESET, .ARB_MASTER_STRAP(strap[0]),
    .HOST_BYTE_ORDER_STRAP(strap[1]), .CONTROL_SOURCE_STRAP(strap[2]),
    .REQ_VALID, .REQ_WRITE, .REQ_BANK, .REQ_ADDR, .REQ_WDATA, .REQ_READY,
    .RD_VALID, .RD_DATA, .ARB_IS_MASTER, .HOST_BIG_ENDIAN, .LINK_CONTROL,
    .MEM_BANK_SELECT_N, .MEM_READ_STROBE_N, .MEM_WRITE_STROBE_N,
    .MEM_ADDR_BUS, .MEM_CTRL_OE, .MEM_DATA_BUS_IN(bus),
    .MEM_DATA_BUS_OUT(bus_out), .MEM_DATA_BUS_OE(bus_oe),
    .PARTNER_OCCUPIED_IN, .OCCUPIED_OUT, .OCCUPIED_OE);
  cmp_mem_model i_mem (.clk(CLOCK), .sel_n(MEM_BANK_SELECT_N),
    .rd_n(MEM_READ_STROBE_N), .wr_n(MEM_WRITE_STROBE_N),
    .addr(MEM_ADDR_BUS), .bus, .dout(mdl_out));
  always #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK)
    if (!(MEM_READ_STROBE_N & MEM_WRITE_STROBE_N))
      seen <= {MEM_BANK_SELECT_N, MEM_ADDR_BUS};
  always @(posedge CLOCK)
    if (++cyc == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  function automatic logic [31:0] swp(logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset(logic [2:0] s);
    @(posedge CLOCK);
    RESET <= 1;
    strap <= s;
    cfg = s;
    repeat (2) @(posedge CLOCK);
    RESET <= 0;
    @(posedge CLOCK);
    strap <= ~s;
    repeat (2) @(posedge CLOCK);
    #1 chk("straps", s,
      {LINK_CONTROL, HOST_BIG_ENDIAN, ARB_IS_MASTER});
  endtask
  task automatic acc(logic wr, logic [1:0] busy, logic b, logic [15:0] a,
                     logic [31:0] d);
    n = 0;
    @(posedge CLOCK);
    {REQ_VALID, REQ_WRITE, REQ_BANK} <= {1'b1, wr, b};
    {REQ_ADDR, REQ_WDATA} <= {a, d};
    PARTNER_OCCUPIED_IN <= (busy == 2'h1);
    @(posedge CLOCK);
    REQ_VALID <= 0;
    if (busy == 2'h1)
    begin
      repeat (8) @(posedge CLOCK);
      #1 chk("hold off", 0, {OCCUPIED_OUT, MEM_CTRL_OE});
      @(posedge CLOCK);
      PARTNER_OCCUPIED_IN <= 0;
    end
    if (busy == 2'h2)
    begin
      // Partner claims in our claim cycle: only the master carries on
      @(posedge CLOCK);
      PARTNER_OCCUPIED_IN <= 1;
      @(posedge CLOCK);
      #1 chk("yield", cfg[0], OCCUPIED_OUT);
      @(posedge CLOCK);
      PARTNER_OCCUPIED_IN <= 0;
    end
    do
    begin
      @(posedge CLOCK);
      #1;
    end while ((wr ? REQ_READY : RD_VALID) !== 1 && ++n < 50);
    if (busy == 2'h0) chk("latency", wr + 1 + ACCESS_CYCLES, n);
    chk("addr", {~(2'h1 << b), a}, seen);
    if (wr) chk("stored", cfg[1] ? swp(d) : d, i_mem.mem[{b, a[5:0]}]);
    else chk("rdata", d, RD_DATA);
  endtask
  initial
  begin
    logic b;
    logic [15:0] a;
    void'($urandom(26487));
    for (int i = 0; i < 8; i++)
    begin
      do_reset(3'(i));
      for (int k = 0; k < 4; k++)
      begin
        w = k == 0 ? 32'h0102_0304 : $urandom;
        a = k == 0 ? 16'h0 : k == 3 ? 16'hffff : 16'($urandom);
        b = 1'($urandom);
        acc(1, k == 1 ? 2'h1 : k == 3 ? 2'h2 : 2'h0, b, a, w);
        acc(0, k == 2 ? 2'h1 : k == 3 ? 2'h2 : 2'h0, b, a, w);
      end
      $display("test %0d done", i);
    end
    wrap_up();
  end
endmodule
